// ==== inc/io_cell_pkg.sv ====
package io_cell_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    localparam int ADDR_W = 12;
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;

    // =====================================================================
    // Control register fields
    // =====================================================================
    localparam int CTRL_W = 8;
    localparam int IN_DDR_BIT = 0;
    localparam int OUT_MODE_LSB = 1;
    localparam int FLT_MODE_LSB = 3;
    localparam int LRST_ASYNC_BIT = 5;
    localparam int IN_SRVAL_BIT = 6;
    localparam int OUT_SRVAL_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h02;

    // =====================================================================
    // Status register fields
    // =====================================================================
    localparam int STATUS_CELL_LSB = 0;
    localparam int STATUS_OE_BIT = 8;
    localparam int STATUS_PAD_BIT = 9;

    // The float register always returns to driving on set/reset.
    localparam logic FLT_SRVAL = 1'b0;

    // Route taken by the output data and by the float control.
    typedef enum logic [1:0] {
        PM_DIRECT = 2'b00,
        PM_REG = 2'b01,
        PM_LATCH = 2'b10,
        PM_DDR = 2'b11
    } path_mode_e;

endpackage

// ==== design/io_cell.sv ====
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Overview of operation
// - Input register loads pad when enabled
// - Synchronous set/reset loads input register value
// - Asynchronous set/reset forces input register immediately
// - Chip-wide set/reset forces input and output registers
// - DDR input shares enable and pad input
// - DDR input registers sample on own clocks
// - DDR input sync reset per own clock
// - Output register loads fabric data when enabled
// - Synchronous set/reset loads output register value
// - Asynchronous set/reset forces output register immediately
// - Output has direct and latch routes
// - DDR output pad follows last clocked register
// - DDR output registers share one enable
// - DDR output sync reset per own clock
// - Float control high floats the pad
// - Float control may pass a latch
// - Chip-wide float forces high impedance
// - Float register samples control on edge
// - Float register loads only when enabled
// - Float register reset returns pad driving
// - DDR float registers use output clocks
module io_cell (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Register bus.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [io_cell_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Cell clocks.
    input wire logic input_clock_a_i,
    input wire logic input_clock_b_i,
    input wire logic output_clock_a_i,
    input wire logic output_clock_b_i,
    // Cell controls.
    input wire logic input_capture_enable_i,
    input wire logic output_capture_enable_i,
    input wire logic float_capture_enable_i,
    input wire logic local_set_reset_i,
    input wire logic chip_wide_set_reset_i,
    input wire logic chip_wide_float_i,
    // Fabric data.
    input wire logic fabric_output_data_a_i,
    input wire logic fabric_output_data_b_i,
    input wire logic float_control_a_i,
    input wire logic float_control_b_i,
    output logic captured_input_a_o,
    output logic captured_input_b_o,
    // Pad.
    input wire logic pad_i,
    output logic pad_o,
    output logic pad_oe_o
);

    // =====================================================================
    // Input synchronisers
    // =====================================================================
    localparam int NSYNC = 15;
    localparam int S_PAD = 0;
    localparam int S_ICA = 1;
    localparam int S_ICB = 2;
    localparam int S_OCA = 3;
    localparam int S_OCB = 4;
    localparam int S_IN_EN = 5;
    localparam int S_OUT_EN = 6;
    localparam int S_FLT_EN = 7;
    localparam int S_LRST = 8;
    localparam int S_CRST = 9;
    localparam int S_CFLT = 10;
    localparam int S_DAT_A = 11;
    localparam int S_DAT_B = 12;
    localparam int S_FCTL_A = 13;
    localparam int S_FCTL_B = 14;

    // Storage slots: six registers and two latches.
    localparam int NCELL = 8;
    localparam int C_IN_A = 0;
    localparam int C_IN_B = 1;
    localparam int C_OUT_A = 2;
    localparam int C_OUT_B = 3;
    localparam int C_FLT_A = 4;
    localparam int C_FLT_B = 5;
    localparam int C_OUT_LAT = 6;
    localparam int C_FLT_LAT = 7;

    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] prev_q;

    // Every cell pin lives outside this clock; all take the same two stages.
    assign raw = {float_control_b_i, float_control_a_i,
                  fabric_output_data_b_i, fabric_output_data_a_i,
                  chip_wide_float_i, chip_wide_set_reset_i,
                  local_set_reset_i, float_capture_enable_i,
                  output_capture_enable_i, input_capture_enable_i,
                  output_clock_b_i, output_clock_a_i,
                  input_clock_b_i, input_clock_a_i, pad_i};

    // First stage feeds only the second stage.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    // A third copy gives the rising-edge detection of the cell clocks.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_q <= '0;
        end else begin
            prev_q <= sync2_q;
        end
    end

    logic ia_rise;
    logic ib_rise;
    logic oa_rise;
    logic ob_rise;
    logic lrst_s;
    logic crst_s;
    logic cflt_s;

    // Data and clocks are delayed alike, so data ahead of a clock edge stays ahead.
    assign ia_rise = sync2_q[S_ICA] & ~prev_q[S_ICA];
    assign ib_rise = sync2_q[S_ICB] & ~prev_q[S_ICB];
    assign oa_rise = sync2_q[S_OCA] & ~prev_q[S_OCA];
    assign ob_rise = sync2_q[S_OCB] & ~prev_q[S_OCB];
    assign lrst_s = sync2_q[S_LRST];
    assign crst_s = sync2_q[S_CRST];
    assign cflt_s = sync2_q[S_CFLT];

    // =====================================================================
    // Register bus slave
    // =====================================================================
    logic [io_cell_pkg::CTRL_W-1:0] ctrl_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic access;
    logic hit;
    logic [31:0] status;

    // Each access gets exactly one wait state.
    assign access = psel_i & penable_i;
    assign hit = (paddr_i == io_cell_pkg::CTRL_OFFSET) |
                 (paddr_i == io_cell_pkg::STATUS_OFFSET);

    // Answer strobe, read data and error are all settled together.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~hit;
            if (access && !pready_q && !pwrite_i) begin
                if (paddr_i == io_cell_pkg::CTRL_OFFSET) begin
                    prdata_q <= {{(32 - io_cell_pkg::CTRL_W){1'b0}}, ctrl_q};
                end else if (paddr_i == io_cell_pkg::STATUS_OFFSET) begin
                    prdata_q <= status;
                end else begin
                    prdata_q <= 32'h00000000;
                end
            end
        end
    end

    // Control word; writes to status or unmapped space are dropped.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q <= io_cell_pkg::CTRL_RESET;
        end else if (access && pready_q && pwrite_i && paddr_i == io_cell_pkg::CTRL_OFFSET) begin
            ctrl_q <= pwdata_i[io_cell_pkg::CTRL_W-1:0];
        end
    end

    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign prdata_o = prdata_q;

    // =====================================================================
    // Configuration decode
    // =====================================================================
    logic in_ddr;
    logic lrst_async;
    logic in_sv;
    logic out_sv;
    io_cell_pkg::path_mode_e out_mode;
    io_cell_pkg::path_mode_e flt_mode;

    assign in_ddr = ctrl_q[io_cell_pkg::IN_DDR_BIT];
    assign lrst_async = ctrl_q[io_cell_pkg::LRST_ASYNC_BIT];
    assign in_sv = ctrl_q[io_cell_pkg::IN_SRVAL_BIT];
    assign out_sv = ctrl_q[io_cell_pkg::OUT_SRVAL_BIT];
    assign out_mode = io_cell_pkg::path_mode_e'(ctrl_q[io_cell_pkg::OUT_MODE_LSB+:2]);
    assign flt_mode = io_cell_pkg::path_mode_e'(ctrl_q[io_cell_pkg::FLT_MODE_LSB+:2]);

    // =====================================================================
    // Storage elements
    // =====================================================================
    logic [NCELL-1:0] cell_ev;
    logic [NCELL-1:0] cell_ce;
    logic [NCELL-1:0] cell_d;
    logic [NCELL-1:0] cell_sv;
    logic [NCELL-1:0] cell_q;

    // Second registers only clock in DDR mode; latches follow while gate is high.
    assign cell_ev = {sync2_q[S_OCA], sync2_q[S_OCA],
                      ob_rise & (flt_mode == io_cell_pkg::PM_DDR), oa_rise,
                      ob_rise & (out_mode == io_cell_pkg::PM_DDR), oa_rise,
                      ib_rise & in_ddr, ia_rise};
    // Pairs share one enable, so both halves see the same edge of it.
    assign cell_ce = {sync2_q[S_FLT_EN], sync2_q[S_OUT_EN],
                      sync2_q[S_FLT_EN], sync2_q[S_FLT_EN],
                      sync2_q[S_OUT_EN], sync2_q[S_OUT_EN],
                      sync2_q[S_IN_EN], sync2_q[S_IN_EN]};
    assign cell_d = {sync2_q[S_FCTL_A], sync2_q[S_DAT_A],
                     sync2_q[S_FCTL_B], sync2_q[S_FCTL_A],
                     sync2_q[S_DAT_B], sync2_q[S_DAT_A],
                     sync2_q[S_PAD], sync2_q[S_PAD]};
    assign cell_sv = {io_cell_pkg::FLT_SRVAL, out_sv,
                      io_cell_pkg::FLT_SRVAL, io_cell_pkg::FLT_SRVAL,
                      out_sv, out_sv, in_sv, in_sv};

    // One slot per element; set/reset outranks the enable, a dead enable holds.
    for (genvar gi = 0; gi < NCELL; gi++) begin : g_cell
        logic q;
        always_ff @(posedge ref_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                q <= 1'b0;
            end else if (crst_s) begin
                q <= cell_sv[gi];
            end else if (lrst_s && lrst_async) begin
                q <= cell_sv[gi];
            end else if (lrst_s && cell_ev[gi]) begin
                q <= cell_sv[gi];
            end else if (cell_ev[gi] && cell_ce[gi]) begin
                q <= cell_d[gi];
            end
        end
        assign cell_q[gi] = q;
    end

    assign captured_input_a_o = cell_q[C_IN_A];
    assign captured_input_b_o = cell_q[C_IN_B];

    // =====================================================================
    // DDR hand-over between halves
    // =====================================================================
    logic last_ob_q;
    logic last_tb_q;

    // Remembers which half clocked last; the second clock wins a tie.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last_ob_q <= 1'b0;
        end else if (ob_rise) begin
            last_ob_q <= 1'b1;
        end else if (oa_rise) begin
            last_ob_q <= 1'b0;
        end
    end

    // Same tracking for the float pair, both on the output clocks.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last_tb_q <= 1'b0;
        end else if (ob_rise) begin
            last_tb_q <= 1'b1;
        end else if (oa_rise) begin
            last_tb_q <= 1'b0;
        end
    end

    // =====================================================================
    // Pad drive
    // =====================================================================
    logic pad_d;
    logic float_d;
    logic pad_q;
    logic pad_oe_q;

    // Route selection costs one reference cycle but keeps the pad glitch free.
    always_comb begin
        case (out_mode)
            io_cell_pkg::PM_DIRECT: pad_d = sync2_q[S_DAT_A];
            io_cell_pkg::PM_REG: pad_d = cell_q[C_OUT_A];
            io_cell_pkg::PM_LATCH: pad_d = cell_q[C_OUT_LAT];
            io_cell_pkg::PM_DDR: pad_d = last_ob_q ? cell_q[C_OUT_B] : cell_q[C_OUT_A];
            default: pad_d = sync2_q[S_DAT_A];
        endcase
    end

    // High on the selected float source means the pad floats.
    always_comb begin
        case (flt_mode)
            io_cell_pkg::PM_DIRECT: float_d = sync2_q[S_FCTL_A];
            io_cell_pkg::PM_REG: float_d = cell_q[C_FLT_A];
            io_cell_pkg::PM_LATCH: float_d = cell_q[C_FLT_LAT];
            io_cell_pkg::PM_DDR: float_d = last_tb_q ? cell_q[C_FLT_B] : cell_q[C_FLT_A];
            default: float_d = sync2_q[S_FCTL_A];
        endcase
    end

    // Chip-wide float overrides every local source.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pad_q <= 1'b0;
            pad_oe_q <= 1'b0;
        end else begin
            pad_q <= pad_d;
            pad_oe_q <= ~float_d & ~cflt_s;
        end
    end

    assign pad_o = pad_q;
    assign pad_oe_o = pad_oe_q;

    // Status view of every storage element and of the pad.
    always_comb begin
        status = 32'h00000000;
        status[io_cell_pkg::STATUS_CELL_LSB+:NCELL] = cell_q;
        status[io_cell_pkg::STATUS_OE_BIT] = pad_oe_q;
        status[io_cell_pkg::STATUS_PAD_BIT] = pad_q;
    end

    // =====================================================================
    // Checks
    // =====================================================================
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    in_capture_a: assert property ((ia_rise && sync2_q[S_IN_EN] && !lrst_s && !crst_s) |=>
        captured_input_a_o == $past(sync2_q[S_PAD]))
        else $error("input register missed an enabled capture");

    in_sync_rst_a: assert property ((ia_rise && lrst_s && !crst_s) |=>
        captured_input_a_o == $past(in_sv))
        else $error("input register ignored synchronous set/reset");

    in_async_rst_a: assert property ((lrst_s && lrst_async) |=>
        (captured_input_a_o == $past(in_sv)) && (cell_q[C_OUT_A] == $past(out_sv)))
        else $error("asynchronous set/reset did not force registers");

    chip_reset_a: assert property (crst_s |=>
        (captured_input_a_o == $past(in_sv)) && (cell_q[C_OUT_A] == $past(out_sv)))
        else $error("chip-wide set/reset did not force registers");

    ddr_in_b_a: assert property ((ib_rise && in_ddr && sync2_q[S_IN_EN] && !lrst_s && !crst_s) |=>
        captured_input_b_o == $past(sync2_q[S_PAD]))
        else $error("second input register missed its capture");

    in_hold_a: assert property ((!ia_rise && !crst_s && !lrst_s) |=> $stable(captured_input_a_o))
        else $error("input register changed without a clock edge");

    out_reg_pad_a: assert property ((out_mode == io_cell_pkg::PM_REG && oa_rise && sync2_q[S_OUT_EN]
        && !lrst_s && !crst_s) ##1 (out_mode == io_cell_pkg::PM_REG) |=>
        pad_o == $past(sync2_q[S_DAT_A], 2))
        else $error("pad did not show registered fabric data");

    ddr_out_b_a: assert property ((out_mode == io_cell_pkg::PM_DDR && ob_rise && sync2_q[S_OUT_EN]
        && !lrst_s && !crst_s) ##1 (out_mode == io_cell_pkg::PM_DDR) |=>
        pad_o == $past(sync2_q[S_DAT_B], 2))
        else $error("pad did not follow the second output register");

    flt_direct_a: assert property ((flt_mode == io_cell_pkg::PM_DIRECT && !cflt_s) |=>
        pad_oe_o == !$past(sync2_q[S_FCTL_A]))
        else $error("direct float control not reflected on the pad");

    chip_float_a: assert property (cflt_s |=> !pad_oe_o)
        else $error("chip-wide float did not release the pad");

    flt_reg_a: assert property ((oa_rise && sync2_q[S_FLT_EN] && !lrst_s && !crst_s) |=>
        cell_q[C_FLT_A] == $past(sync2_q[S_FCTL_A]))
        else $error("float register missed an enabled capture");

    flt_rst_a: assert property ((oa_rise && lrst_s && !crst_s) |=> !cell_q[C_FLT_A])
        else $error("float register not cleared by set/reset");

endmodule

// ==== tb/pad_side_model.sv ====
`timescale 1ns/1ps
// =====================================================================
// Pad side: outside driver and pad wire
// =====================================================================
module pad_side_model (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Cell driver and outside driver.
    input wire logic drive_level_i,
    input wire logic drive_en_i,
    input wire logic ext_en_i,
    input wire logic ext_val_i,
    // Level seen at the pad.
    output logic pad_seen_o
);
    logic last_q;

    // Remember the last level so that a floating pad can wander away from it.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last_q <= 1'b0;
        end else begin
            last_q <= pad_seen_o;
        end
    end

    // The pad has no pull, so an undriven pad toggles instead of keeping a stale level.
    always_comb begin
        if (drive_en_i) begin
            pad_seen_o = drive_level_i;
        end else if (ext_en_i) begin
            pad_seen_o = ext_val_i;
        end else begin
            pad_seen_o = ~last_q;
        end
    end
endmodule

// ==== tb/ddr_io_cell_registers_test.sv ====
`timescale 1ns/1ps
module ddr_io_cell_registers_test;
    // =================================================================
    // Signals
    // =================================================================
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [31:0] prdata_o, rd;
    logic pready_o, pslverr_o, cap_a, cap_b, pad_i, pad_o, pad_oe_o, er;
    logic [3:0] cclk = 4'h0;
    logic in_en = 1'b0, out_en = 1'b0, flt_en = 1'b0, loc_rst = 1'b0, chip_rst = 1'b0, chip_flt = 1'b0;
    logic dat_a = 1'b0, dat_b = 1'b0, flt_a = 1'b0, flt_b = 1'b0, ext_val = 1'b0;
    logic [31:0] rng = 32'h00007D0E;
    int err_total = 0;
    int cmp_count = 0;

    // Free-running 20 MHz clock.
    always #25 ref_clk_i = ~ref_clk_i;

    io_cell dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .input_clock_a_i(cclk[0]), .input_clock_b_i(cclk[1]),
        .output_clock_a_i(cclk[2]), .output_clock_b_i(cclk[3]), .input_capture_enable_i(in_en),
        .output_capture_enable_i(out_en), .float_capture_enable_i(flt_en), .local_set_reset_i(loc_rst),
        .chip_wide_set_reset_i(chip_rst), .chip_wide_float_i(chip_flt), .fabric_output_data_a_i(dat_a),
        .fabric_output_data_b_i(dat_b), .float_control_a_i(flt_a), .float_control_b_i(flt_b),
        .captured_input_a_o(cap_a), .captured_input_b_o(cap_b), .pad_i(pad_i), .pad_o(pad_o),
        .pad_oe_o(pad_oe_o));

    pad_side_model pad_side (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .drive_level_i(pad_o),
        .drive_en_i(pad_oe_o), .ext_en_i(1'b1), .ext_val_i(ext_val), .pad_seen_o(pad_i));

    // =================================================================
    // Helpers
    // =================================================================
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // One APB transfer; the master holds the request until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 20 && pready_o !== 1'b1) begin
            err_total++;
            stop_test();
        end
    endtask

    // Cell clock pulse; phases are long enough for the two-flop synchronisers.
    task automatic pulse(input int k);
        @(posedge ref_clk_i);
        cclk[k] <= 1'b1;
        cyc(3);
        cclk[k] <= 1'b0;
        cyc(5);
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic held(input logic q, input logic d, input logic en);
        return en ? d : q;
    endfunction

    task automatic load(input logic v);
        ext_val <= v;
        dat_a <= v;
        in_en <= 1'b1;
        out_en <= 1'b1;
        pulse(0);
        pulse(2);
    endtask

    // =================================================================
    // Main sequence
    // =================================================================
    initial begin
        logic q, v;
        int m;
        cyc(3);
        rstn_i <= 1'b1;
        apb(1'b0, io_cell_pkg::CTRL_OFFSET, 32'h0);
        chk("ctrl_reset", {24'h0, io_cell_pkg::CTRL_RESET}, rd);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped_err", 32'h1, er);
        chk("unmapped_data", 32'h0, rd);
        apb(1'b1, io_cell_pkg::STATUS_OFFSET, 32'hFFFFFFFF);
        apb(1'b0, io_cell_pkg::CTRL_OFFSET, 32'h0);
        chk("ctrl_kept", 32'h02, rd);
        // Registered input: the cell floats the pad so the outside drives it.
        flt_a <= 1'b1;
        // The release takes a few cycles; a capture before it would see the cell's own level.
        cyc(6);
        q = 1'b0;
        repeat (12) begin
            rng = xs(rng);
            ext_val <= rng[0];
            in_en <= rng[1];
            pulse(0);
            q = held(q, rng[0], rng[1]);
            chk("cap_a", q, cap_a);
        end
        flt_a <= 1'b0;
        q = 1'b0;
        repeat (12) begin
            rng = xs(rng);
            dat_a <= rng[2];
            out_en <= rng[3];
            pulse(2);
            q = held(q, rng[2], rng[3]);
            chk("pad_reg", q, pad_o);
        end
        for (m = 1; m >= 0; m--) begin
            flt_a <= m[0];
            cyc(6);
            chk("oe_direct", !m[0], pad_oe_o);
        end
        // Synchronous, asynchronous and chip-wide set/reset, to both values.
        flt_a <= 1'b1;
        for (m = 0; m < 6; m++) begin
            v = m[0];
            apb(1'b1, io_cell_pkg::CTRL_OFFSET, {24'h0, v, v, m[2:1] == 2'd1, 5'h02});
            load(~v);
            if (m[2:1] == 2'd2) chip_rst <= 1'b1;
            else loc_rst <= 1'b1;
            if (m[2:1] == 2'd0) begin
                pulse(0);
                pulse(2);
            end else begin
                cyc(8);
            end
            chk("cap_rst", v, cap_a);
            chk("pad_rst", v, pad_o);
            loc_rst <= 1'b0;
            chip_rst <= 1'b0;
        end
        flt_a <= 1'b0;
        chip_flt <= 1'b1;
        cyc(6);
        chk("oe_chip_float", 32'h0, pad_oe_o);
        apb(1'b0, io_cell_pkg::STATUS_OFFSET, 32'h0);
        chk("status_oe", 32'h0, rd[io_cell_pkg::STATUS_OE_BIT]);
        chip_flt <= 1'b0;
        cyc(6);
        chk("oe_back", 32'h1, pad_oe_o);
        // Double-rate input; the shared pad level changes between the two edges.
        apb(1'b1, io_cell_pkg::CTRL_OFFSET, 32'h03);
        flt_a <= 1'b1;
        in_en <= 1'b1;
        cyc(6);
        repeat (8) begin
            rng = xs(rng);
            ext_val <= rng[0];
            pulse(0);
            ext_val <= rng[1];
            pulse(1);
            chk("ddr_in_a", rng[0], cap_a);
            chk("ddr_in_b", rng[1], cap_b);
        end
        ext_val <= 1'b1;
        pulse(0);
        pulse(1);
        loc_rst <= 1'b1;
        pulse(0);
        chk("ddr_rst_a", 32'h0, cap_a);
        chk("ddr_rst_b_wait", 32'h1, cap_b);
        pulse(1);
        chk("ddr_rst_b", 32'h0, cap_b);
        loc_rst <= 1'b0;
        // Double-rate output; the shared enable stays put across both edges.
        apb(1'b1, io_cell_pkg::CTRL_OFFSET, 32'h06);
        flt_a <= 1'b0;
        out_en <= 1'b1;
        repeat (8) begin
            rng = xs(rng);
            dat_a <= rng[0];
            dat_b <= rng[1];
            pulse(2);
            chk("ddr_pad_a", rng[0], pad_o);
            pulse(3);
            chk("ddr_pad_b", rng[1], pad_o);
        end
        // Double-rate output reset: each half clears on its own clock only.
        dat_a <= 1'b1;
        dat_b <= 1'b1;
        pulse(2);
        pulse(3);
        loc_rst <= 1'b1;
        pulse(2);
        chk("ddr_out_rst_a", 32'h0, pad_o);
        apb(1'b0, io_cell_pkg::STATUS_OFFSET, 32'h0);
        chk("ddr_out_b_wait", 32'h1, rd[io_cell_pkg::STATUS_CELL_LSB + 3]);
        pulse(3);
        chk("ddr_out_rst_b", 32'h0, pad_o);
        loc_rst <= 1'b0;
        // Direct route, then the latch route open and closed.
        apb(1'b1, io_cell_pkg::CTRL_OFFSET, 32'h00);
        repeat (4) begin
            rng = xs(rng);
            dat_a <= rng[0];
            cyc(6);
            chk("pad_direct", rng[0], pad_o);
        end
        apb(1'b1, io_cell_pkg::CTRL_OFFSET, 32'h04);
        cclk[2] <= 1'b1;
        dat_a <= 1'b1;
        cyc(6);
        chk("latch_open", 32'h1, pad_o);
        cclk[2] <= 1'b0;
        cyc(4);
        dat_a <= 1'b0;
        cyc(6);
        chk("latch_hold", 32'h1, pad_o);
        // Float control through the latch: follows while open, holds once closed.
        apb(1'b1, io_cell_pkg::CTRL_OFFSET, 32'h12);
        flt_en <= 1'b1;
        flt_a <= 1'b1;
        cclk[2] <= 1'b1;
        cyc(6);
        chk("oe_flatch_open", 32'h0, pad_oe_o);
        cclk[2] <= 1'b0;
        cyc(4);
        flt_a <= 1'b0;
        cyc(6);
        chk("oe_flatch_hold", 32'h0, pad_oe_o);
        // Float register: load, hold while disabled, reset to driving.
        apb(1'b1, io_cell_pkg::CTRL_OFFSET, 32'h0A);
        flt_a <= 1'b1;
        flt_en <= 1'b1;
        pulse(2);
        chk("oe_freg", 32'h0, pad_oe_o);
        flt_a <= 1'b0;
        flt_en <= 1'b0;
        pulse(2);
        chk("oe_fhold", 32'h0, pad_oe_o);
        loc_rst <= 1'b1;
        pulse(2);
        chk("oe_frst", 32'h1, pad_oe_o);
        loc_rst <= 1'b0;
        apb(1'b1, io_cell_pkg::CTRL_OFFSET, 32'h1A);
        flt_a <= 1'b1;
        flt_b <= 1'b0;
        flt_en <= 1'b1;
        pulse(2);
        chk("oe_fddr_a", 32'h0, pad_oe_o);
        pulse(3);
        chk("oe_fddr_b", 32'h1, pad_oe_o);
        stop_test();
    end

    // A hang anywhere counts as a mismatch and closes the run.
    initial begin
        repeat (6000) @(posedge ref_clk_i);
        err_total++;
        stop_test();
    end
endmodule
